// ---- mode_page_regs.vh ----
`ifndef MODE_PAGE_REGS_VH
`define MODE_PAGE_REGS_VH

// Register byte addresses on the AHB-Lite slave
`define ADDR_CTRL        8'h00
`define ADDR_COLOR_SEL   8'h04
`define ADDR_BUF_RATIO   8'h08
`define ADDR_STATUS      8'h0c
`define ADDR_PAGE_IN     8'h10
`define ADDR_OCCUPANCY   8'h14

// Page framing values
`define VEND_PAGE_LEN    8'h06
`define DISC_PAGE_CODE   6'h02
`define DISC_PAGE_LEN    8'h0a
`define VEND_PAGE_CODE   6'h00

// Vendor page body byte 7 fields
`define B7_MATRIX_LOAD   0
`define B7_GAMMA_LOAD    1
`define B7_LED           2
// Vendor page body byte 8 fields
`define B8_LAMP          0
`define B8_SENSOR_PWR    1
`define B8_POLARITY      2
`define B8_BYPASS        3
`define B8_PEAKING       4

// Reset values
`define RST_COLOR_SEL    8'h02
`define RST_BUF_RATIO    8'h80

// Lamp hold time: two minutes at 100 MHz
// Sized at 36 bits so the product does not wrap at 32
`define LAMP_HOLD_S      36'h078
`define CLK_HZ           36'h005f5e100
`define LAMP_HOLD_CYC    (`LAMP_HOLD_S * `CLK_HZ)

`endif

// ---- lamp_timer.v ----
`include "mode_page_regs.vh"

module lamp_timer #(
  parameter [35:0] HOLD_CYC = `LAMP_HOLD_CYC
) (
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_i,
  // Events
  input  wire       lamp_req_i,
  input  wire       activity_i,
  input  wire       new_cmd_i,
  // Lamp drive
  output wire       lamp_on_o
);

  reg [35:0] count_r;    // Cycles left before lamp goes dark
  reg        lit_r;      // Lamp state
  reg        req_d_r;    // Request one cycle ago, for edge detect
  // Only a fresh request relights; a level would undo the timeout
  wire       req_rise = lamp_req_i && !req_d_r;

  // Lamp stays lit while counter runs; activity restarts the count
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_r <= 36'h0;
      lit_r   <= 1'b0;
      req_d_r <= 1'b0;
    end else begin
      req_d_r <= lamp_req_i;
      if (new_cmd_i || req_rise) begin
        count_r <= HOLD_CYC;    // R11
        lit_r   <= 1'b1;        // R9
      end else if (!lamp_req_i) begin
        lit_r   <= 1'b0;        // R9
        count_r <= 36'h0;
      end else if (activity_i && lit_r) begin
        count_r <= HOLD_CYC;    // R10
      end else if (lit_r) begin
        if (count_r <= 36'h1)
          lit_r <= 1'b0;        // R10
        count_r <= count_r - 36'h1;
      end
    end
  end

  assign lamp_on_o = lit_r;

endmodule

// ---- mode_page_decoder.v ----
// Notes on behaviour
// R1: Host sets vendor page length to 0x06
// R2: LED bit lights amber indicator
// R3: Gamma load bit fills identity gamma table
// R4: Matrix load bit loads identity colour matrix
// R5: Peaking bit enables edge-peaking filter
// R6: Bypass bit routes data around correction
// R7: Polarity bit one makes black 0xFF
// R8: Sensor power follows lamp or scan
// R9: Lamp bit turns lamp on/off
// R10: Lamp off after two idle minutes
// R11: New command lights lamp two minutes; with the lamp bit clear the lamp goes dark the next cycle
// R12: Colour select field picks sensor lines
// R13: Host uses page code 0x02
// R14: Host sets disconnect page length 0x0A
// R15: Wait request holds data till ratio
// R16: Host should program ratio 128
// R17: Host zeroes all reserved fields
// R18: Control bits decoded from bytes 7, 8
// R19: Default loads act once per page
//
// Register access over AHB-Lite and the register offsets were decided locally.
`include "mode_page_regs.vh"

module mode_page_decoder #(
  parameter [35:0] LAMP_HOLD = `LAMP_HOLD_CYC,
  parameter        OCC_W     = 16
) (
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_i,
  // AHB-Lite slave
  input  wire             hsel_i,
  input  wire [7:0]       haddr_i,
  input  wire [1:0]       htrans_i,
  input  wire             hwrite_i,
  input  wire [2:0]       hsize_i,
  input  wire [31:0]      hwdata_i,
  input  wire             hready_i,
  output wire [31:0]      hrdata_o,
  output wire             hreadyout_o,
  output wire             hresp_o,
  // Command and bus activity from the SCSI front end
  input  wire             new_cmd_i,
  input  wire             bus_activity_i,
  input  wire             scan_active_i,
  // Data status request with wait bit
  input  wire             status_req_i,
  input  wire             status_wait_i,
  input  wire [OCC_W-1:0] buf_occ_i,
  input  wire [OCC_W-1:0] buf_size_i,
  // Controls to the scanner datapath
  output reg              indicator_led_ctrl_o,
  output reg              peaking_filter_enable_o,
  output reg              correction_stage_bypass_o,
  output reg              black_is_ff_o,
  output reg              sensor_array_power_o,
  output wire             lamp_on_o,
  output reg  [7:0]       color_sel_o,
  output reg              data_release_o,
  // Gamma and matrix reload
  output reg              gamma_load_o,
  output reg  [7:0]       gamma_addr_o,
  output reg  [7:0]       gamma_data_o,
  output reg              matrix_load_o,
  output reg  [71:0]      matrix_o
);

  // One-hot page parser states
  // One-hot keeps each state decode down to a single bit
  localparam [3:0] ST_IDLE = 4'b0001;  // Waiting for header
  localparam [3:0] ST_HDR  = 4'b0010;  // Collecting header bytes 1-5
  localparam [3:0] ST_BODY = 4'b0100;  // Collecting body bytes
  localparam [3:0] ST_GAMA = 4'b1000;  // Writing identity gamma

  // Bus phase capture
  // Only one transfer can be in its data phase at a time
  reg        wr_pend_r;       // Data phase of a write is pending
  reg  [7:0] addr_r;          // Address captured in address phase
  reg  [31:0] rdata_r;        // Read data
  // Parser state
  // b7_r and b8_r are both the page images and the control register
  reg  [3:0] state_r;
  reg  [3:0] idx_r;           // Byte index within page
  reg  [5:0] page_code_r;     // Captured page code
  reg  [7:0] page_len_r;      // Captured length
  reg  [7:0] b7_r;            // Vendor byte 7 image
  reg  [7:0] b8_r;            // Vendor byte 8 image
  reg  [7:0] buf_ratio_r;     // Buffer full ratio
  reg        gamma_pend_r;    // Gamma reload owed
  reg  [7:0] gam_idx_r;       // Next identity entry to emit
  reg        waiting_r;       // Wait-mode request outstanding
  reg        bad_page_r;      // Last page had a bad code or length
  reg        lamp_req_r;      // Software lamp request

  // Decode of the bus address phase and the page port
  wire       addr_ph  = hsel_i && hready_i && htrans_i[1];
  wire       page_wr  = wr_pend_r && (addr_r == `ADDR_PAGE_IN);
  wire [7:0] pbyte    = hwdata_i[7:0];

  // Threshold test: occupancy * 255 >= ratio * size
  // Cross-multiplied so no divider is needed; the left side is
  // built as occ*256 - occ, which fits in 24 bits for a 16-bit
  // occupancy, and the compare runs at that width.
  function reached;
    input [OCC_W-1:0] occ;
    input [OCC_W-1:0] size;
    input [7:0]       ratio;
    begin
      reached = ({occ, 8'h00} - {8'h00, occ}) >= (ratio * size);
    end
  endfunction

  // Lamp timeout lives in its own counter
  // The hold count is wide (minutes at the system clock), so it is
  // kept apart from the page logic and shortened only in simulation
  lamp_timer #(
    .HOLD_CYC   (LAMP_HOLD)
  ) u_lamp (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .lamp_req_i (lamp_req_r),
    .activity_i (bus_activity_i),
    .new_cmd_i  (new_cmd_i),
    .lamp_on_o  (lamp_on_o)
  );

  // Bus is zero-wait and always OKAY
  // Error responses are never needed: unmapped reads give zero
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_r;

  // Address phase capture and read data
  // Read data is registered at the address edge, so it stands for the
  // whole data phase and the slave never needs a wait state.
  // Only one slave sits on this bus, so hready is simply our own
  // hreadyout looped back by the fabric.
  // Read data returns to zero after one cycle.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      rdata_r   <= 32'h0;
    end else begin
      wr_pend_r <= addr_ph && hwrite_i;
      addr_r    <= haddr_i;
      rdata_r   <= 32'h0;
      if (addr_ph && !hwrite_i) begin
        // Reads are decoded in the address phase
        case (haddr_i)
          `ADDR_CTRL:      rdata_r <= {16'h0, b8_r, b7_r};
          `ADDR_COLOR_SEL: rdata_r <= {24'h0, color_sel_o};
          `ADDR_BUF_RATIO: rdata_r <= {24'h0, buf_ratio_r};
          // Status bits are live values, read without side effects
          `ADDR_STATUS:    rdata_r <= {26'h0, bad_page_r, waiting_r,
                                       sensor_array_power_o, lamp_on_o,
                                       gamma_pend_r, data_release_o};
          default:         rdata_r <= 32'h0;  // Unmapped reads as zero
        endcase
      end
    end
  end

  // Page byte parser, gamma fill and register writes
  // Each write to the page port carries one byte in its low lane.
  // Byte 0 moves the parser out of idle, bytes 1-5 are the header,
  // and the rest are body bytes counted by idx_r.
  // A page whose code or length is wrong raises the bad-page flag
  // and drops back to idle; later bytes of that page are then taken
  // as the start of a fresh page, so software must not rely on the
  // parser resynchronising without a clean page behind it.
  // Direct register writes share this process so that a page byte
  // and a register write to the same field cannot fight.
  // The gamma walk runs here too, so page bytes are ignored meanwhile.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r      <= ST_IDLE;
      idx_r        <= 4'h0;
      page_code_r  <= 6'h0;
      page_len_r   <= 8'h0;
      b7_r         <= 8'h00;
      b8_r         <= 8'h00;
      buf_ratio_r  <= `RST_BUF_RATIO;
      color_sel_o  <= `RST_COLOR_SEL;  // Green line default
      gamma_pend_r <= 1'b0;
      gamma_load_o <= 1'b0;
      gam_idx_r    <= 8'h00;
      gamma_addr_o <= 8'h00;
      gamma_data_o <= 8'h00;
      matrix_load_o <= 1'b0;
      matrix_o     <= 72'h0;
      bad_page_r   <= 1'b0;
    end else begin
      matrix_load_o <= 1'b0;
      gamma_load_o  <= 1'b0;
      // Direct register writes
      // A page byte in the same cycle overrides these, as it comes later
      if (wr_pend_r && addr_r == `ADDR_CTRL) begin
        b7_r <= hwdata_i[7:0];
        b8_r <= hwdata_i[15:8];
      end
      if (wr_pend_r && addr_r == `ADDR_COLOR_SEL)
        color_sel_o <= hwdata_i[7:0];
      if (wr_pend_r && addr_r == `ADDR_BUF_RATIO)
        buf_ratio_r <= hwdata_i[7:0];
      case (state_r)
        ST_IDLE: begin
          // Any page write opens a new page
          if (page_wr) begin
            idx_r   <= 4'h1;
            state_r <= ST_HDR;
          end
        end
        ST_HDR: begin
          // Bytes 4 and 5 carry the page code and length;
          // the reserved header bytes are not checked
          if (page_wr) begin
            if (idx_r == 4'h4)
              page_code_r <= pbyte[5:0];
            if (idx_r == 4'h5)
              page_len_r <= pbyte;
            idx_r <= idx_r + 4'h1;
            if (idx_r == 4'h5)
              state_r <= ST_BODY;
          end
        end
        ST_BODY: begin
          // Length is checked on every body byte, so a wrong page
          // is refused at its first body byte
          if (page_wr) begin
            idx_r <= idx_r + 4'h1;
            if (page_code_r == `VEND_PAGE_CODE) begin
              if (page_len_r != `VEND_PAGE_LEN) begin
                bad_page_r <= 1'b1;   // R1
                state_r    <= ST_IDLE;
              end else if (idx_r == 4'h7) begin
                b7_r <= pbyte;        // R18
              end else if (idx_r == 4'h8) begin
                b8_r <= pbyte;        // R18
              end else if (idx_r == 4'h9) begin
                color_sel_o <= pbyte; // R12
              end else if (idx_r == 4'hb) begin
                bad_page_r <= 1'b0;
                // Reloads fire once as the page completes
                // Byte 7 is already held, so a set bit acts exactly once
                if (b7_r[`B7_MATRIX_LOAD]) begin
                  matrix_load_o <= 1'b1;   // R19
                  matrix_o <= {8'h01, 24'h0, 8'h01, 24'h0, 8'h01};  // R4
                end
                if (b7_r[`B7_GAMMA_LOAD]) begin
                  gamma_pend_r <= 1'b1;    // R19
                  gam_idx_r    <= 8'h00;   // Walk starts at entry zero
                  state_r      <= ST_GAMA;
                end else begin
                  state_r <= ST_IDLE;
                end
              end
            end else if (page_code_r == `DISC_PAGE_CODE) begin
              // Only the buffer full ratio is kept from this page
              if (page_len_r != `DISC_PAGE_LEN) begin
                bad_page_r <= 1'b1;   // R14
                state_r    <= ST_IDLE;
              end else if (idx_r == 4'h6) begin
                buf_ratio_r <= pbyte;  // R15
              end else if (idx_r == 4'hf) begin
                bad_page_r <= 1'b0;
                state_r    <= ST_IDLE;
              end
            end else begin
              bad_page_r <= 1'b1;     // R13
              state_r    <= ST_IDLE;
            end
          end
        end
        ST_GAMA: begin
          // Identity table, one entry a cycle; address and data leave
          // together from the same index so every strobe pairs them
          // Page writes that arrive meanwhile are ignored
          gamma_load_o <= 1'b1;       // R3
          gamma_addr_o <= gam_idx_r;
          gamma_data_o <= gam_idx_r;  // R3
          gam_idx_r    <= gam_idx_r + 8'h01;
          if (gam_idx_r == 8'hff) begin
            gamma_pend_r <= 1'b0;
            state_r      <= ST_IDLE;
          end
        end
        // Unreachable one-hot codes fall back to idle
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Decoded control outputs
  // Registered one cycle behind the byte images so every datapath
  // control changes on a clock edge and never glitches.
  // The lamp request goes to the timer, which owns the lamp itself;
  // the timer relights on a rising request only, and a low request darkens it.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      indicator_led_ctrl_o      <= 1'b0;
      peaking_filter_enable_o   <= 1'b0;
      correction_stage_bypass_o <= 1'b0;
      black_is_ff_o             <= 1'b0;
      sensor_array_power_o      <= 1'b0;
      lamp_req_r                <= 1'b0;
    end else begin
      indicator_led_ctrl_o      <= b7_r[`B7_LED];         // R2
      peaking_filter_enable_o   <= b8_r[`B8_PEAKING];     // R5
      correction_stage_bypass_o <= b8_r[`B8_BYPASS];      // R6
      black_is_ff_o             <= b8_r[`B8_POLARITY];    // R7
      lamp_req_r                <= b8_r[`B8_LAMP];        // R9
      // Array follows lamp, or only scans when bit is clear
      sensor_array_power_o <= b8_r[`B8_SENSOR_PWR] ? lamp_on_o
                                                   : scan_active_i;  // R8
    end
  end

  // Wait-mode data release against the ratio threshold
  // A request without the wait bit is answered at once.
  // With the wait bit, the request is remembered and the threshold is
  // tested every cycle until it is met; the release is a single pulse.
  // A plain request that arrives while one waits does not cancel it.
  // The ratio may be rewritten while waiting and takes effect at once.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      waiting_r      <= 1'b0;
      data_release_o <= 1'b0;
    end else begin
      data_release_o <= 1'b0;
      if (status_req_i && !status_wait_i)
        data_release_o <= 1'b1;
      // Wait bit set, or a request already waiting
      else if ((status_req_i && status_wait_i) || waiting_r) begin
        if (reached(buf_occ_i, buf_size_i, buf_ratio_r)) begin
          data_release_o <= 1'b1;   // R15
          waiting_r      <= 1'b0;
        end else begin
          waiting_r <= 1'b1;        // R15
        end
      end
    end
  end

endmodule

// ---- mode_page_props.sv ----
module mode_page_props #(
  parameter [35:0] LAMP_HOLD = 36'd100
) (
  // Clock and reset
  input wire        sys_clk_i,
  input wire        rst_i,
  // Host side events
  input wire        new_cmd_i,
  input wire        bus_activity_i,
  input wire        scan_active_i,
  input wire        status_req_i,
  input wire        status_wait_i,
  input wire [15:0] buf_occ_i,
  // Datapath controls
  input wire        sensor_array_power_o,
  input wire        lamp_on_o,
  input wire [7:0]  color_sel_o,
  input wire        data_release_o,
  input wire        gamma_load_o,
  input wire [7:0]  gamma_addr_o,
  input wire [7:0]  gamma_data_o,
  input wire        matrix_load_o,
  input wire [71:0] matrix_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  reg [35:0] idle_cnt_r; // Quiet cycles while the lamp burns
  // Any bus event restarts the idle count
  always @(posedge sys_clk_i) begin
    if (rst_i || new_cmd_i || bus_activity_i || !lamp_on_o)
      idle_cnt_r <= 36'h0;
    else
      idle_cnt_r <= idle_cnt_r + 36'h1;
  end
  property p_lamp_idle_off; idle_cnt_r <= LAMP_HOLD + 36'h3; endproperty
  a_lamp_idle_off: assert property (p_lamp_idle_off) else $error("lamp outlived idle hold");
  property p_cmd_lamp; new_cmd_i |-> ##[1:2] lamp_on_o; endproperty
  a_cmd_lamp: assert property (p_cmd_lamp) else $error("command left lamp dark");
  property p_mat_ident; matrix_load_o |-> matrix_o == 72'h010000000100000001; endproperty
  a_mat_ident: assert property (p_mat_ident) else $error("matrix not identity");
  property p_mat_once; matrix_load_o |=> (!matrix_load_o) [*8]; endproperty
  a_mat_once: assert property (p_mat_once) else $error("matrix reload repeated");
  property p_gam_ident; gamma_load_o |-> gamma_data_o == gamma_addr_o; endproperty
  a_gam_ident: assert property (p_gam_ident) else $error("gamma entry not identity");
  property p_gam_step;
    gamma_load_o && $past(gamma_load_o) |-> gamma_addr_o == $past(gamma_addr_o) + 8'h01;
  endproperty
  a_gam_step: assert property (p_gam_step) else $error("gamma address skipped");
  property p_rel_now; status_req_i && !status_wait_i |=> data_release_o; endproperty
  a_rel_now: assert property (p_rel_now) else $error("plain request not released");
  property p_rel_hold;
    status_req_i && status_wait_i && buf_occ_i == 16'h0 ##1 buf_occ_i == 16'h0 |-> !data_release_o;
  endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("release from empty buffer");
  property p_sensor;
    sensor_array_power_o |-> $past(scan_active_i) || $past(lamp_on_o) || lamp_on_o;
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor powered without cause");
  property p_color_rst; $fell(rst_i) |-> color_sel_o == 8'h02; endproperty
  a_color_rst: assert property (p_color_rst) else $error("colour select not green");
endmodule

// ---- scsi_host_model.sv ----
`include "mode_page_regs.vh"
module scsi_host_model (
  // Clock
  input wire        sys_clk_i,
  // Command and status lines
  output reg        new_cmd_o,
  output reg        bus_activity_o,
  output reg        scan_active_o,
  output reg        status_req_o,
  output reg        status_wait_o,
  output reg [15:0] buf_occ_o,
  output reg [15:0] buf_size_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet bus at start
  initial begin
    {new_cmd_o, bus_activity_o, scan_active_o, status_req_o, status_wait_o} = 5'h0;
    buf_occ_o = 16'h0;
    buf_size_o = 16'h0;
  end
  // One command, seen also as bus traffic
  task command();
    @(posedge sys_clk_i);
    new_cmd_o <= 1'b1;
    bus_activity_o <= 1'b1;
    @(posedge sys_clk_i);
    new_cmd_o <= 1'b0;
    bus_activity_o <= 1'b0;
  endtask
  // Data status request, wait bit as given
  task request(input logic wt);
    @(posedge sys_clk_i);
    status_req_o <= 1'b1;
    status_wait_o <= wt;
    @(posedge sys_clk_i);
    status_req_o <= 1'b0;
  endtask
  // Page image byte; b7 carries the full ratio on the disconnect page
  function automatic logic [7:0] page_byte(input logic disc, input int i,
      input logic [5:0] code, input logic [7:0] b7, input logic [7:0] b8, input logic [7:0] b9);
    case (i)
      4: page_byte = {2'b00, code};
      5: page_byte = disc ? `DISC_PAGE_LEN : `VEND_PAGE_LEN;
      6: page_byte = disc ? b7 : 8'h00;
      7: page_byte = disc ? 8'h00 : b7;
      8: page_byte = disc ? 8'h00 : b8;
      9: page_byte = disc ? 8'h00 : b9;
      default: page_byte = 8'h00;
    endcase
  endfunction
endmodule

// ---- scanner_mode_page_decoder_tb.sv ----
`include "mode_page_regs.vh"
module scanner_mode_page_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [35:0] HOLD = 36'd100; // Short lamp hold for simulation
  reg sys_clk_i = 1'b0, rst_i = 1'b1, hsel_i, hwrite_i;
  reg [7:0] haddr_i;
  reg [1:0] htrans_i;
  reg [31:0] hwdata_i;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, new_cmd_i, bus_activity_i, scan_active_i, status_req_i;
  wire status_wait_i, led, peak, byp, blk, sensor_array_power_o, lamp_on_o;
  wire data_release_o, gamma_load_o, matrix_load_o;
  wire [15:0] buf_occ_i, buf_size_i;
  wire [7:0] color_sel_o, gamma_addr_o, gamma_data_o;
  wire [71:0] matrix_o;
  int miscompares = 0, checks_done = 0, cyc = 0, gcnt = 0, gbad = 0, mcnt = 0, rcnt = 0;
  logic [71:0] mat;
  logic [31:0] rd;
  always #5 sys_clk_i = ~sys_clk_i;
  scsi_host_model host (.sys_clk_i, .new_cmd_o(new_cmd_i), .bus_activity_o(bus_activity_i),
    .scan_active_o(scan_active_i), .status_req_o(status_req_i), .status_wait_o(status_wait_i),
    .buf_occ_o(buf_occ_i), .buf_size_o(buf_size_i));
  mode_page_decoder #(.LAMP_HOLD(HOLD)) dut (.sys_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
    .hresp_o, .new_cmd_i, .bus_activity_i, .scan_active_i, .status_req_i, .status_wait_i,
    .buf_occ_i, .buf_size_i, .indicator_led_ctrl_o(led), .peaking_filter_enable_o(peak),
    .correction_stage_bypass_o(byp), .black_is_ff_o(blk), .sensor_array_power_o, .lamp_on_o,
    .color_sel_o, .data_release_o, .gamma_load_o, .gamma_addr_o, .gamma_data_o,
    .matrix_load_o, .matrix_o);
  // Verdict and end of run
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single AHB transfer; waits on hready, no assumed latency
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk_i);
    {hsel_i, htrans_i, hwrite_i, haddr_i} <= {1'b1, 2'b10, w, a};
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  // Whole page, one byte per word
  task page(input logic disc, input logic [5:0] code, input logic [7:0] b7, b8, b9);
    logic [31:0] r;
    for (int i = 0; i < (disc ? 16 : 12); i++)
      ahb(1'b1, `ADDR_PAGE_IN, {24'h0, host.page_byte(disc, i, code, b7, b8, b9)}, r);
  endtask
  // Watchdog and output monitors; hangs end as a failure
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      test_done();
    end
    if (gamma_load_o === 1'b1) begin
      gcnt++;
      if (gamma_data_o !== gamma_addr_o) gbad++;
    end
    if (matrix_load_o === 1'b1) begin
      mcnt++;
      mat = matrix_o;
    end
    if (data_release_o === 1'b1) rcnt++;
  end
  initial begin
    {hsel_i, hwrite_i, haddr_i, htrans_i, hwdata_i} = '0;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk(color_sel_o, 8'h02);
    ahb(1'b0, `ADDR_BUF_RATIO, 32'h0, rd);
    chk(rd, 32'h80);
    ahb(1'b0, `ADDR_OCCUPANCY, 32'h0, rd); // Unmapped word reads zero
    chk(rd, 32'h0);
    chk({hresp_o, hreadyout_o}, 2'b01); // Zero-wait OKAY slave
    page(1'b0, `VEND_PAGE_CODE, 8'h07, 8'h1f, 8'h05);
    repeat (3) @(posedge sys_clk_i);
    chk({led, peak, byp, blk, lamp_on_o, sensor_array_power_o}, 6'h3f);
    chk(color_sel_o, 8'h05);
    repeat (300) @(posedge sys_clk_i); // Gamma fill plus idle hold
    chk(gcnt, 256);
    chk(gbad, 0);
    chk(mcnt, 1);
    chk(mat, 72'h010000000100000001);
    chk({lamp_on_o, sensor_array_power_o}, 2'b00);
    host.command();
    repeat (2) @(posedge sys_clk_i);
    chk({lamp_on_o, sensor_array_power_o}, 2'b11);
    page(1'b0, `VEND_PAGE_CODE, 8'h00, 8'h00, 8'h02);
    repeat (3) @(posedge sys_clk_i);
    chk({led, peak, byp, blk, lamp_on_o, sensor_array_power_o}, 6'h00);
    host.scan_active_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk(sensor_array_power_o, 1'b1);
    page(1'b1, `DISC_PAGE_CODE, 8'd128, 8'h00, 8'h00);
    host.buf_size_o <= 16'd256;
    host.request(1'b1);
    repeat (5) @(posedge sys_clk_i);
    host.buf_occ_o <= 16'd128; // 128*255 stays below 128*256
    repeat (5) @(posedge sys_clk_i);
    chk(rcnt, 0);
    host.buf_occ_o <= 16'd129;
    repeat (5) @(posedge sys_clk_i);
    chk(rcnt, 1);
    host.request(1'b0);
    repeat (3) @(posedge sys_clk_i); // Monitor counts the pulse one edge after it
    chk(rcnt, 2);
    page(1'b1, 6'h03, 8'd128, 8'h00, 8'h00); // Wrong page code is refused
    ahb(1'b0, `ADDR_STATUS, 32'h0, rd);
    chk(rd[5], 1'b1);
    test_done();
  end
endmodule
bind mode_page_decoder mode_page_props #(.LAMP_HOLD(LAMP_HOLD)) u_props (.sys_clk_i, .rst_i,
  .new_cmd_i, .bus_activity_i, .scan_active_i, .status_req_i, .status_wait_i, .buf_occ_i,
  .sensor_array_power_o, .lamp_on_o, .color_sel_o, .data_release_o, .gamma_load_o,
  .gamma_addr_o, .gamma_data_o, .matrix_load_o, .matrix_o);
